/* File: rtl/mse_cfg.svh */
// mission sequencer engine constants: offsets, fields, reset values, timing
// assumes inclusion by bare name from the design module
`ifndef MSE_CFG_SVH
`define MSE_CFG_SVH
// ----------------------------------------------------------------
// apb register offsets (byte addresses)
// ----------------------------------------------------------------
`define MSE_OFF_CTRL 12'h000
`define MSE_OFF_STATUS 12'h004
`define MSE_OFF_ERRMASK 12'h008
`define MSE_OFF_STEP 12'h00c
`define MSE_OFF_PROG_ADDR 12'h010
`define MSE_OFF_PROG_DATA 12'h014
`define MSE_OFF_SCRATCH 12'h018
// ----------------------------------------------------------------
// ctrl fields
// ----------------------------------------------------------------
`define MSE_CTRL_FIRST_BOOT 0
`define MSE_CTRL_SKIP_RELOAD 1
`define MSE_CTRL_PROG_UNLOCK 2
// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define MSE_PROG_DEPTH 64
`define MSE_PC_W 6
`define MSE_STEP_RST 16'h007d
`define MSE_ERRMASK_RST 8'h00
`define MSE_TIMER_MAX 6'h3f
`endif

/* File: rtl/mse_pkg.sv */
// mission sequencer engine types
// assumes mse_cfg.svh defines constants
`default_nettype none
package mse_pkg;
   // instruction opcodes
   typedef enum logic [3:0] {
      op_masked_page_zero_write = 4'h0,
      op_immediate_register_write = 4'h1,
      op_masked_register_write = 4'h2,
      op_voltage_setpoint_write = 4'h3,
      op_regulator_mode_write = 4'h4,
      op_scratch_masked_write = 4'h5,
      op_scratch_load_from_address = 4'h6,
      op_wait = 4'h7,
      op_immediate_delay = 4'h8,
      op_scratch_delay = 4'h9,
      op_trigger_destination_set = 4'ha,
      op_trigger_enable_mask = 4'hb,
      op_end = 4'hc,
      op_page_zero_bit_write = 4'hd,
      op_page_zero_window_write = 4'he,
      op_scratch_immediate_load = 4'hf
   } mse_op_t;
   // one-hot sequencer states
   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_fetch = 6'h02,
      st_exec = 6'h04,
      st_delay = 6'h08,
      st_wait = 6'h10,
      st_rdwait = 6'h20
   } mse_state_t;
   // 32-bit instruction: op, sub, addr, data, mask; fills one program word
   // limitation: only the low address byte fits, upper map bits go out as zero
   // wait reuses mask: type in [7:6], timeout in [5:0]
   typedef struct packed {
      mse_op_t op;
      logic [3:0] sub;
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] mask;
   } mse_instr_t;
   // register-map write / read request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [9:0] addr;
      logic [7:0] wdata;
      logic [7:0] wmask;
   } mse_reg_req_t;
   // categorized error triggers
   typedef struct packed {
      logic severe;
      logic moderate;
      logic irq_only;
   } mse_err_t;
endpackage
`default_nettype wire

/* File: rtl/mse_top.sv */
// mission sequencer engine: decodes stored instructions onto register map
// assumes apb master, register map that answers reads in fixed latency via map_rvalid
`include "mse_cfg.svh"
`default_nettype none
module mse_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wake_from_standby,   // pulse: standby to init
   input wire logic wake_from_recovery,  // pulse: recovery to init
   input wire logic mission_reached,     // level: in a mission state
   input wire logic transition_req,      // pulse: new state decided
   input wire logic [`MSE_PC_W-1:0] transition_addr,
   input wire logic [7:0] err_src,       // raw error sources
   input wire logic [7:0] err_sev_class, // 1 = severe among unmasked
   input wire logic [15:0] cond_in,      // wait / trigger conditions
   input wire logic [3:0] buck_active_set, // 1 = second setpoint active
   output logic reload_conf,   // pulse: reset+reload preserved group
   output logic reload_other,  // pulse: reset+reload other registers
   output var mse_pkg::mse_reg_req_t map_req,
   input wire logic [7:0] map_rdata,
   input wire logic map_rvalid,
   output var mse_pkg::mse_err_t err_cat,
   output logic seq_busy
);
   // ----------------------------------------------------------------
   // state and storage
   // ----------------------------------------------------------------
   mse_pkg::mse_state_t state_ff, nxt_state;
   logic [31:0] prog_mem [0:`MSE_PROG_DEPTH-1]; // sequencer program
   logic [`MSE_PC_W-1:0] pc_ff;
   mse_pkg::mse_instr_t ir_ff;
   logic [7:0] sreg_ff [0:3];   // scratch registers
   logic first_boot_ff, skip_reload_ff, unlock_ff;
   logic [7:0] errmask_ff;
   logic [15:0] step_ff;        // one less than the clocks per delay step
   logic [15:0] prescale_ff;
   logic [5:0] tick_cnt_ff, limit_ff;
   logic [`MSE_PC_W-1:0] prog_addr_ff;
   logic [`MSE_PC_W-1:0] trig_dest_ff [0:3];
   logic [3:0] trig_en_ff;
   logic [1:0] cond_prev_ff;
   logic delayed_wr_ff;         // write pending after delay
   logic apb_wr, apb_rd;
   logic step_tick, timer_done;
   logic cond_now, cond_met;
   logic [3:0] trig_hit;
   // ----------------------------------------------------------------
   // apb slave: zero wait, unmapped reads zero with error
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && penable && !pwrite;
   // configuration bits; preserved group reloads from defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_boot_ff <= 1'b0;
         skip_reload_ff <= 1'b0;
         unlock_ff <= 1'b0;
         step_ff <= `MSE_STEP_RST;
         errmask_ff <= `MSE_ERRMASK_RST;
      end else if (wake_from_standby && !skip_reload_ff) begin
         // other registers always reload on a wake that is not skipped
         unlock_ff <= 1'b0;
         errmask_ff <= `MSE_ERRMASK_RST;
         // preserved group only until the first boot has completed
         if (!first_boot_ff) begin
            skip_reload_ff <= 1'b0;
            step_ff <= `MSE_STEP_RST;
         end
      end else if (wake_from_recovery) begin
         // skip bit ignored here
         unlock_ff <= 1'b0;
         errmask_ff <= `MSE_ERRMASK_RST;
         if (!first_boot_ff) begin
            step_ff <= `MSE_STEP_RST;
            skip_reload_ff <= 1'b0;
         end
      end else if (apb_wr) begin
         case (paddr)
            `MSE_OFF_CTRL: begin
               first_boot_ff <= pwdata[`MSE_CTRL_FIRST_BOOT];
               skip_reload_ff <= pwdata[`MSE_CTRL_SKIP_RELOAD];
               unlock_ff <= pwdata[`MSE_CTRL_PROG_UNLOCK];
            end
            `MSE_OFF_ERRMASK: errmask_ff <= pwdata[7:0];
            `MSE_OFF_STEP: step_ff <= pwdata[15:0];
            default: ;
         endcase
      end
   end
   // reload pulses toward the register map
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_conf <= 1'b0;
         reload_other <= 1'b0;
      end else begin
         reload_conf <= (wake_from_standby && !skip_reload_ff && !first_boot_ff) ||
                        (wake_from_recovery && !first_boot_ff);
         reload_other <= (wake_from_standby && !skip_reload_ff) || wake_from_recovery;
      end
   end
   // program loading: only while unlocked and not in a mission state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_addr_ff <= '0;
      end else if (apb_wr && paddr == `MSE_OFF_PROG_ADDR) begin
         prog_addr_ff <= pwdata[`MSE_PC_W-1:0];
      end else if (apb_wr && paddr == `MSE_OFF_PROG_DATA && unlock_ff && !mission_reached) begin
         prog_addr_ff <= prog_addr_ff + 1'b1;
      end
   end
   always_ff @(posedge pclk) begin
      if (apb_wr && paddr == `MSE_OFF_PROG_DATA && unlock_ff && !mission_reached) begin
         prog_mem[prog_addr_ff] <= pwdata;
      end
   end
   // read mux
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pslverr <= 1'b0;
         prdata <= '0;
         if (psel && !penable) begin
            case (paddr)
               `MSE_OFF_CTRL: prdata <= {29'h0, unlock_ff, skip_reload_ff, first_boot_ff};
               `MSE_OFF_STATUS: prdata <= {16'h0, 2'h0, pc_ff, 2'h0, state_ff};
               `MSE_OFF_ERRMASK: prdata <= {24'h0, errmask_ff};
               `MSE_OFF_STEP: prdata <= {16'h0, step_ff};
               `MSE_OFF_PROG_ADDR: prdata <= {26'h0, prog_addr_ff};
               `MSE_OFF_PROG_DATA: prdata <= prog_mem[prog_addr_ff];
               `MSE_OFF_SCRATCH: prdata <= {sreg_ff[3], sreg_ff[2], sreg_ff[1], sreg_ff[0]};
               default: pslverr <= !pwrite;
            endcase
            if (pwrite && paddr > `MSE_OFF_SCRATCH) begin
               pslverr <= 1'b1;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // error hierarchy: mask, drop irq-only, classify
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cat <= '0;
      end else begin
         err_cat.irq_only <= |(err_src & errmask_ff);
         err_cat.severe <= |(err_src & ~errmask_ff & err_sev_class);
         err_cat.moderate <= |(err_src & ~errmask_ff & ~err_sev_class);
      end
   end
   // triggers: 0 severe, 1 moderate, 2-3 condition inputs
   assign trig_hit = trig_en_ff & {cond_in[1:0], err_cat.moderate, err_cat.severe};
   // ----------------------------------------------------------------
   // delay step timer: counts 0..63 step units
   // ----------------------------------------------------------------
   assign step_tick = (prescale_ff >= step_ff);
   assign timer_done = (tick_cnt_ff >= limit_ff);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_ff <= '0;
         tick_cnt_ff <= '0;
      end else if (state_ff == mse_pkg::st_exec) begin
         prescale_ff <= '0;
         tick_cnt_ff <= '0;
      end else if (step_tick) begin
         prescale_ff <= '0;
         if (tick_cnt_ff != `MSE_TIMER_MAX) begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
         end
      end else begin
         prescale_ff <= prescale_ff + 1'b1;
      end
   end
   // wait condition: index in sub, type in mask[7:6] low/high/rise/fall
   assign cond_now = cond_in[ir_ff.sub];
   always_comb begin
      case (ir_ff.mask[7:6])
         2'h0: cond_met = !cond_now;
         2'h1: cond_met = cond_now;
         2'h2: cond_met = cond_now && !cond_prev_ff[0];
         default: cond_met = !cond_now && cond_prev_ff[0];
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_prev_ff <= '0;
      end else begin
         cond_prev_ff <= {cond_prev_ff[0], cond_now};
      end
   end
   // ----------------------------------------------------------------
   // sequencer state machine
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         mse_pkg::st_idle: if (mission_reached && (transition_req || |trig_hit)) nxt_state = mse_pkg::st_fetch;
         mse_pkg::st_fetch: nxt_state = mse_pkg::st_exec;
         mse_pkg::st_exec: begin
            case (ir_ff.op)
               mse_pkg::op_end: nxt_state = mse_pkg::st_idle;
               mse_pkg::op_wait: nxt_state = mse_pkg::st_wait;
               mse_pkg::op_immediate_delay, mse_pkg::op_scratch_delay,
               mse_pkg::op_voltage_setpoint_write, mse_pkg::op_regulator_mode_write:
                  nxt_state = mse_pkg::st_delay;
               mse_pkg::op_scratch_load_from_address: nxt_state = mse_pkg::st_rdwait;
               default: nxt_state = mse_pkg::st_fetch;
            endcase
         end
         mse_pkg::st_delay: if (timer_done) nxt_state = mse_pkg::st_fetch;
         mse_pkg::st_wait: if (cond_met || timer_done) nxt_state = mse_pkg::st_fetch;
         mse_pkg::st_rdwait: if (map_rvalid) nxt_state = mse_pkg::st_fetch;
         default: nxt_state = mse_pkg::st_idle;
      endcase
      if (!mission_reached) nxt_state = mse_pkg::st_idle;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_ff <= mse_pkg::st_idle;
      else state_ff <= nxt_state;
   end
   assign seq_busy = (state_ff != mse_pkg::st_idle);
   // program counter and instruction fetch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_ff <= '0;
         ir_ff <= '0;
      end else if (state_ff == mse_pkg::st_idle) begin
         if (transition_req) pc_ff <= transition_addr;
         else if (trig_hit[0]) pc_ff <= trig_dest_ff[0];
         else if (trig_hit[1]) pc_ff <= trig_dest_ff[1];
         else if (trig_hit[2]) pc_ff <= trig_dest_ff[2];
         else if (trig_hit[3]) pc_ff <= trig_dest_ff[3];
      end else if (state_ff == mse_pkg::st_fetch) begin
         ir_ff <= prog_mem[pc_ff];
         pc_ff <= pc_ff + 1'b1;
      end
   end
   // delay limit, trigger setup, scratch loads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_ff <= '0;
         trig_en_ff <= '0;
         for (int i = 0; i < 4; i++) begin
            sreg_ff[i] <= '0;
            trig_dest_ff[i] <= '0;
         end
      end else if (state_ff == mse_pkg::st_exec) begin
         limit_ff <= ir_ff.mask[5:0];
         case (ir_ff.op)
            mse_pkg::op_scratch_delay: limit_ff <= sreg_ff[ir_ff.sub[1:0]][5:0];
            mse_pkg::op_trigger_destination_set: trig_dest_ff[ir_ff.sub[1:0]] <= ir_ff.addr[5:0];
            mse_pkg::op_trigger_enable_mask: trig_en_ff <= ir_ff.data[3:0];
            mse_pkg::op_scratch_immediate_load: sreg_ff[ir_ff.sub[1:0]] <= ir_ff.data;
            default: ;
         endcase
      end else if (state_ff == mse_pkg::st_rdwait && map_rvalid) begin
         sreg_ff[ir_ff.sub[1:0]] <= map_rdata;
      end
   end
   // register-map requests; wmask bit 1 = bit is written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_req <= '0;
         delayed_wr_ff <= 1'b0;
      end else begin
         map_req.wr <= 1'b0;
         map_req.rd <= 1'b0;
         if (state_ff == mse_pkg::st_exec) begin
            map_req.addr <= {2'h0, ir_ff.addr};
            map_req.wdata <= ir_ff.data;
            map_req.wmask <= ~ir_ff.mask;
            case (ir_ff.op)
               mse_pkg::op_masked_page_zero_write: begin
                  map_req.wr <= 1'b1;
                  map_req.addr <= {2'h0, ir_ff.addr[7:0]};
               end
               mse_pkg::op_immediate_register_write: begin
                  map_req.wr <= 1'b1;
                  map_req.wmask <= 8'hff;
               end
               mse_pkg::op_masked_register_write: map_req.wr <= 1'b1;
               mse_pkg::op_voltage_setpoint_write: begin
                  // addr holds buck index*2; selector folds
                  map_req.addr <= {2'h0, ir_ff.addr[7:1], (ir_ff.sub[1] ?
                     (buck_active_set[ir_ff.sub[3:2]] ^ ir_ff.sub[0]) : ir_ff.sub[0])};
                  map_req.wmask <= 8'hff;
                  delayed_wr_ff <= 1'b1;
               end
               mse_pkg::op_regulator_mode_write: begin
                  map_req.wdata <= {4'h0, ir_ff.data[3:0]};
                  delayed_wr_ff <= 1'b1;
               end
               mse_pkg::op_scratch_masked_write: begin
                  map_req.wr <= 1'b1;
                  map_req.wdata <= sreg_ff[ir_ff.sub[1:0]];
               end
               mse_pkg::op_scratch_load_from_address: map_req.rd <= 1'b1;
               mse_pkg::op_page_zero_bit_write: begin
                  map_req.wr <= 1'b1;
                  map_req.addr <= {2'h0, ir_ff.addr[7:0]};
                  map_req.wdata <= {7'h0, ir_ff.data[0]} << ir_ff.sub[2:0];
                  map_req.wmask <= 8'h01 << ir_ff.sub[2:0];
               end
               mse_pkg::op_page_zero_window_write: begin
                  map_req.wr <= 1'b1;
                  map_req.addr <= {2'h0, ir_ff.addr[7:0]};
                  map_req.wdata <= ir_ff.data << ir_ff.sub[2:0];
                  // mask bits keep, as for the other masked writes
                  map_req.wmask <= (~ir_ff.mask) << ir_ff.sub[2:0];
               end
               default: ;
            endcase
         end else if (state_ff == mse_pkg::st_delay && timer_done && delayed_wr_ff) begin
            map_req.wr <= 1'b1; // write lands once delay elapsed
            delayed_wr_ff <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_end_stops_seq: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == mse_pkg::st_exec && ir_ff.op == mse_pkg::op_end |=> state_ff == mse_pkg::st_idle)
      else $error("end did not stop task");
   a_skip_no_reload: assert property (@(posedge pclk) disable iff (!presetn)
      wake_from_standby && skip_reload_ff && !wake_from_recovery |=> !reload_other && !reload_conf)
      else $error("reload despite skip bit");
   a_recovery_reload: assert property (@(posedge pclk) disable iff (!presetn)
      wake_from_recovery |=> reload_other)
      else $error("recovery did not reload");
   a_full_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == mse_pkg::st_exec && ir_ff.op == mse_pkg::op_immediate_register_write
      |=> map_req.wr && map_req.wmask == 8'hff)
      else $error("full write not full");
   a_delay_no_write: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == mse_pkg::st_delay && !timer_done |=> !map_req.wr)
      else $error("write before delay");
   a_severe_masked: assert property (@(posedge pclk) disable iff (!presetn)
      (err_src & ~errmask_ff) == 8'h00 |=> !err_cat.severe && !err_cat.moderate)
      else $error("masked error escaped");
   a_lock_program: assert property (@(posedge pclk) disable iff (!presetn)
      mission_reached && apb_wr && paddr == `MSE_OFF_PROG_DATA |=> $stable(prog_addr_ff))
      else $error("program changed in mission");
   a_fetch_order: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == mse_pkg::st_fetch |=> pc_ff == $past(pc_ff) + 1'b1)
      else $error("pc not sequential");
endmodule
`default_nettype wire

/* File: tb/mse_map_model.sv */
// register map stand-in on the far side of the sequencer
// assumes one clock, map_req wr/rd as one-cycle pulses
`default_nettype none
module mse_map_model #(
   parameter int LAT = 2 // read answer latency, at least 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire mse_pkg::mse_reg_req_t map_req,
   output logic [7:0] map_rdata,
   output logic map_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [LAT-1:0] pend_ff; // reads in flight
   logic [7:0] raddr_ff; // address of last read
   logic [25:0] wlog [16]; // captured writes, addr/data/mask
   int wcnt; // writes seen
   // read pipe: data toggles outside answers so stale values never match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= '0;
         map_rvalid <= 1'b0;
         map_rdata <= 8'h00;
      end else begin
         pend_ff <= {pend_ff[LAT-2:0], map_req.rd};
         if (map_req.rd) raddr_ff <= map_req.addr[7:0];
         map_rvalid <= pend_ff[LAT-1];
         map_rdata <= pend_ff[LAT-1] ? (raddr_ff ^ 8'h5a) : ~map_rdata;
      end
   end
   // write log, read back by the bench in order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wcnt <= 0;
      else if (map_req.wr) begin
         wlog[wcnt[3:0]] <= {map_req.addr, map_req.wdata, map_req.wmask};
         wcnt <= wcnt + 1;
      end
   end
endmodule
`default_nettype wire

/* File: tb/mission_sequencer_engine_bench.sv */
// self-checking bench for the mission sequencer engine
// assumes apb answers through pready, map model on the far side
`default_nettype none
module mission_sequencer_engine_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, reload_conf, reload_other, map_rvalid, seq_busy;
   logic wake_from_standby = 1'b0, wake_from_recovery = 1'b0, mission_reached = 1'b0;
   logic transition_req = 1'b0;
   logic [5:0] transition_addr = 6'h00;
   logic [7:0] err_src = 8'h00, err_sev_class = 8'h00, map_rdata;
   logic [15:0] cond_in = 16'h0000; // wait and trigger conditions
   logic [3:0] buck_active_set = 4'h2; // buck 1 runs on its second setpoint
   mse_pkg::mse_reg_req_t map_req;
   mse_pkg::mse_err_t err_cat;
   int mismatches = 0, tests_run = 0, nc = 0, no = 0;
   mse_top u_mse_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .wake_from_standby, .wake_from_recovery, .mission_reached, .transition_req,
      .transition_addr, .err_src, .err_sev_class, .cond_in, .buck_active_set, .reload_conf,
      .reload_other, .map_req, .map_rdata, .map_rvalid, .err_cat, .seq_busy);
   mse_map_model u_mse_map_model (.pclk, .presetn, .map_req, .map_rdata, .map_rvalid);
   always #4 pclk = ~pclk;
   // reload pulse counters
   always @(posedge pclk) begin
      if (reload_conf === 1'b1) nc++;
      if (reload_other === 1'b1) no++;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   function automatic mse_pkg::mse_instr_t mk(input logic [3:0] op, input logic [3:0] s,
      input logic [9:0] a, input logic [7:0] d, input logic [7:0] m);
      mk = {op, s, a[7:0], d, m}; // only the low address byte is stored
   endfunction
   task automatic print_verdict();
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // step reset value and an unmapped address
   task automatic t_regs();
      apb(1'b0, 12'h00c, 32'h0);
      chk("step", 32'h7d, rd);
      apb(1'b0, 12'h01c, 32'h0);
      chk("slverr", 1, er);
   endtask
   // reload policy table: rec, first_boot, skip, conf, other
   task automatic t_reload();
      logic [4:0] tb [5] = '{5'b00100, 5'b01001, 5'b00011, 5'b11101, 5'b10111};
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 12'h000, {30'h0, tb[i][2], tb[i][3]});
         nc = 0;
         no = 0;
         @(posedge pclk);
         if (tb[i][4]) wake_from_recovery <= 1'b1;
         else wake_from_standby <= 1'b1;
         @(posedge pclk);
         wake_from_recovery <= 1'b0;
         wake_from_standby <= 1'b0;
         repeat (6) @(posedge pclk);
         chk("conf", tb[i][1], nc);
         chk("other", tb[i][0], no);
      end
   endtask
   // severe error, then masked down to interrupt only
   task automatic t_errors();
      err_src <= 8'h01;
      err_sev_class <= 8'h01;
      repeat (4) @(posedge pclk);
      chk("severe", 3'b100, err_cat);
      apb(1'b1, 12'h008, 32'h1);
      repeat (4) @(posedge pclk);
      chk("irq_only", 3'b001, err_cat);
      err_src <= 8'h00;
   endtask
   // full program: every instruction kind, then a task started by a trigger
   task automatic t_program();
      mse_pkg::mse_instr_t pg [18] = '{mk(4'h1, 4'h0, 10'h01d, 8'h55, 8'h00),
         mk(4'h2, 4'h0, 10'h010, 8'h0f, 8'hf0), mk(4'h0, 4'h0, 10'h01d, 8'h80, 8'h0f),
         mk(4'hd, 4'h3, 10'h010, 8'h01, 8'h00), mk(4'he, 4'h2, 10'h01d, 8'h08, 8'hf3),
         mk(4'hf, 4'h2, 10'h000, 8'h15, 8'h00), mk(4'h5, 4'h2, 10'h022, 8'h00, 8'h00),
         mk(4'h3, 4'h6, 10'h040, 8'h33, 8'h03), mk(4'h6, 4'h3, 10'h015, 8'h00, 8'h00),
         mk(4'h4, 4'h1, 10'h02a, 8'h0b, 8'hc4), mk(4'h8, 4'h0, 10'h000, 8'h00, 8'h02),
         mk(4'h9, 4'h2, 10'h000, 8'h00, 8'h00), mk(4'h7, 4'h1, 10'h000, 8'h00, 8'h45),
         mk(4'ha, 4'h2, 10'h010, 8'h00, 8'h00), mk(4'hb, 4'h0, 10'h000, 8'h04, 8'h00),
         mk(4'hc, 4'h0, 10'h000, 8'h00, 8'h00), mk(4'h1, 4'h0, 10'h033, 8'h77, 8'h00),
         mk(4'hc, 4'h0, 10'h000, 8'h00, 8'h00)};
      logic [25:0] ew [9] = '{{10'h01d, 16'h55ff}, {10'h010, 16'h0f0f}, {10'h01d, 16'h80f0},
         {10'h010, 16'h0808}, {10'h01d, 16'h2030}, {10'h022, 16'h15ff}, {10'h041, 16'h33ff},
         {10'h02a, 16'h0b3b}, {10'h033, 16'h77ff}};
      logic [15:0] cw [9] = '{16'hffff, 16'h0fff, 16'hf0ff, 16'h08ff, 16'h30ff, 16'hffff, 16'hffff,
         16'h3bff, 16'hffff};
      logic [25:0] km;
      apb(1'b1, 12'h000, 32'h4);
      apb(1'b1, 12'h00c, 32'h2);
      apb(1'b1, 12'h010, 32'h0);
      for (int i = 0; i < 18; i++) apb(1'b1, 12'h014, pg[i]);
      @(posedge pclk);
      mission_reached <= 1'b1;
      transition_req <= 1'b1;
      @(posedge pclk);
      transition_req <= 1'b0;
      repeat (3) @(posedge pclk);
      for (int n = 0; n < 3000 && seq_busy === 1'b1; n++) @(posedge pclk);
      chk("busy", 0, seq_busy);
      chk("writes", 8, u_mse_map_model.wcnt);
      apb(1'b0, 12'h018, 32'h0);
      chk("scratch2", 8'h15, rd[23:16]);
      chk("scratch3", 8'h4f, rd[31:24]);
      // overwrite of the triggered task's first word must be refused in mission
      apb(1'b1, 12'h010, 32'h10);
      apb(1'b1, 12'h014, 32'hc0000000);
      cond_in <= 16'h0001;
      @(posedge pclk);
      cond_in <= 16'h0000;
      repeat (3) @(posedge pclk);
      for (int n = 0; n < 3000 && seq_busy === 1'b1; n++) @(posedge pclk);
      chk("trig_writes", 9, u_mse_map_model.wcnt);
      for (int i = 0; i < 9; i++) begin
         km = {10'h3ff, cw[i]};
         chk("wlog", ew[i] & km, u_mse_map_model.wlog[i] & km);
      end
      mission_reached <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_reload();
      t_errors();
      t_program();
      print_verdict();
   end
   // hang guard, well past the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      print_verdict();
   end
endmodule
`default_nettype wire
